// *** verilog/flash_status_pkg.sv ***
// Constants, types and state record of the flash write-status reporter
package flash_status_pkg;

	localparam int CLOCK_PERIOD_NS = 25;
	// Protected-target poll windows; plain defaults, tune to the array
	localparam int PROT_PROGRAM_POLL_NS = 2000;
	localparam int ALL_PROT_ERASE_POLL_NS = 50000;
	localparam int PROT_PROGRAM_POLL_CYCLES =
		(PROT_PROGRAM_POLL_NS / CLOCK_PERIOD_NS < 1) ? 1 :
		PROT_PROGRAM_POLL_NS / CLOCK_PERIOD_NS;
	localparam int ALL_PROT_ERASE_POLL_CYCLES =
		(ALL_PROT_ERASE_POLL_NS / CLOCK_PERIOD_NS < 1) ? 1 :
		ALL_PROT_ERASE_POLL_NS / CLOCK_PERIOD_NS;
	// Burst clock below this rate counts as slow
	localparam int SLOW_CLOCK_MHZ = 6;
	localparam int SLOW_PERIOD_CYCLES =
		(1000 / CLOCK_PERIOD_NS + SLOW_CLOCK_MHZ - 1) / SLOW_CLOCK_MHZ;
	localparam logic [15:0] SLOW_PERIOD_LAST = 16'(SLOW_PERIOD_CYCLES - 1);
	localparam logic [15:0] PERIOD_SATURATE = 16'hffff;

	localparam logic [5:0] BOUNDARY_ADDR = 6'h3e;
	localparam logic [1:0] THIRD_CLOCK = 2'h2;
	localparam logic [1:0] THIRD_WRAP = 2'h2;

	localparam int POLL_BIT = 7;
	localparam int BANK_TOGGLE_BIT = 6;
	localparam int TIMEOUT_BIT = 5;
	localparam int TIMER_BIT = 3;
	localparam int SECTOR_TOGGLE_BIT = 2;

	typedef enum logic [2:0] {
		OP_IDLE,
		OP_PROGRAM,
		OP_PROT_POLL,
		OP_ERASE_WINDOW,
		OP_ERASE,
		OP_SUSPEND,
		OP_SUSPEND_PROGRAM,
		OP_FAILED
	} op_state_t;

	typedef struct packed {
		logic chipSelN;
		logic outEnN;
		logic writeEnN;
		logic burstClk;
	} pins_t;

	typedef struct packed {
		pins_t pinMeta;
		pins_t pinSync;
		pins_t pinPrev;
		op_state_t op;
		logic eraseKind;
		logic suspendBase;
		logic pendProgram;
		logic pendSectorErase;
		logic pendChipErase;
		logic [15:0] waitCount;
		logic bankToggle;
		logic sectorToggle;
		logic timeoutFail;
		logic windowClosed;
		logic [15:0] busData;
		logic busOeN;
		logic ready;
		logic readyOeN;
		logic [3:0] latency;
		logic [5:0] burstAddr;
		logic boundaryHold;
		logic [15:0] clkPeriod;
		logic slowClock;
		logic [1:0] thirdCount;
	} state_t;

endpackage

// *** verilog/flash_status_reporter.sv ***
// Write-status reporting and burst ready logic of a NOR flash
//
// Contract
// - Program: poll bit inverted, then true datum
// - Protected program: poll and toggle, then array
// - Erase drives poll zero; done or suspend one
// - All protected erase: poll, toggle, then array
// - Partly protected erase skips protected sectors
// - Poll bit valid from last write rising
// - Final data valid only on following read
// - Ready high means burst data may be taken
// - Ready drops: initial access, 3Eh boundary, slow clock
// - Burst: ready high with output disabled, floats deselected
// - Async mode: ready high selected, floats deselected
// - Busy bank reads invert bank toggle bit
// - Bank toggle valid anywhere in bank, timeout window
// - Suspend program toggles; suspend itself stops toggling (here only the bank toggle stops; sector toggle still flips)
// - Sector toggle only selected sectors, never programming
// - Pulse limit exceeded sets timeout bit
// - Reset command returns to array or suspend read
// - Status only for reads of the busy bank
// - Erase timer bit zero in window, one after
`timescale 1ns/1ps

module flash_status_reporter (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic chipSelN,
	input wire logic outEnN,
	input wire logic writeEnN,
	input wire logic burstClk,
	input wire logic burstMode,
	input wire logic [3:0] initialWait,
	input wire logic [5:0] startAddrLow,
	input wire logic cmdProgram,
	input wire logic cmdSectorErase,
	input wire logic cmdChipErase,
	input wire logic eraseWindowEnd,
	input wire logic cmdSuspend,
	input wire logic cmdResume,
	input wire logic cmdReset,
	input wire logic programDone,
	input wire logic eraseDone,
	input wire logic pulseLimitHit,
	input wire logic targetProtected,
	input wire logic allSelectedProtected,
	input wire logic programDatumMsb,
	input wire logic readBankBusy,
	input wire logic readSectorSelected,
	input wire logic [15:0] arrayData,
	output logic [15:0] busData,
	output logic busOeN,
	output logic ready,
	output logic readyOeN
);

	flash_status_pkg::state_t q;
	flash_status_pkg::state_t next_q;

	logic readActive;
	logic readDone;
	logic weRise;
	logic clkRise;
	logic ceFall;
	logic bankToggles;
	logic sectorToggles;
	logic statusMode;
	logic pollValue;
	logic programBusy;

	always_comb begin
		readActive = !q.pinSync.chipSelN && !q.pinSync.outEnN;
		// A read ends when the output enable or the select rises
		readDone = (q.pinSync.outEnN && !q.pinPrev.outEnN &&
			!q.pinPrev.chipSelN) || (q.pinSync.chipSelN &&
			!q.pinPrev.chipSelN && !q.pinPrev.outEnN);
		weRise = q.pinSync.writeEnN && !q.pinPrev.writeEnN;
		clkRise = q.pinSync.burstClk && !q.pinPrev.burstClk;
		ceFall = !q.pinSync.chipSelN && q.pinPrev.chipSelN;
		programBusy = q.op == flash_status_pkg::OP_PROGRAM ||
			q.op == flash_status_pkg::OP_SUSPEND_PROGRAM;
		bankToggles = programBusy ||
			q.op == flash_status_pkg::OP_PROT_POLL ||
			q.op == flash_status_pkg::OP_ERASE_WINDOW ||
			q.op == flash_status_pkg::OP_ERASE ||
			q.op == flash_status_pkg::OP_FAILED;
		sectorToggles = !programBusy && (q.eraseKind ||
			q.op == flash_status_pkg::OP_SUSPEND) &&
			q.op != flash_status_pkg::OP_IDLE;
		// Unselected sectors of a suspended bank read array data
		statusMode = readBankBusy && q.op != flash_status_pkg::OP_IDLE &&
			!(q.op == flash_status_pkg::OP_SUSPEND &&
			!readSectorSelected);
		if (q.op == flash_status_pkg::OP_SUSPEND) begin
			pollValue = 1'b1;
		end else if (q.eraseKind) begin
			pollValue = 1'b0;
		end else begin
			pollValue = !programDatumMsb;
		end
	end

	always_comb begin
		next_q = q;
		next_q.pinMeta = '{chipSelN, outEnN, writeEnN, burstClk};
		next_q.pinSync = q.pinMeta;
		next_q.pinPrev = q.pinSync;

		case (q.op)
			flash_status_pkg::OP_IDLE,
			flash_status_pkg::OP_SUSPEND: begin
				// Operations start on the last write strobe rising
				if (weRise && q.pendProgram) begin
					next_q.pendProgram = 1'b0;
					next_q.eraseKind = 1'b0;
					next_q.suspendBase =
						q.op == flash_status_pkg::OP_SUSPEND;
					if (targetProtected) begin
						next_q.op = flash_status_pkg::OP_PROT_POLL;
						next_q.waitCount = 16'(
							flash_status_pkg::PROT_PROGRAM_POLL_CYCLES - 1);
					end else if (q.op == flash_status_pkg::OP_SUSPEND) begin
						next_q.op = flash_status_pkg::OP_SUSPEND_PROGRAM;
					end else begin
						next_q.op = flash_status_pkg::OP_PROGRAM;
					end
				end else if (q.op == flash_status_pkg::OP_SUSPEND) begin
					if (cmdResume) begin
						next_q.op = flash_status_pkg::OP_ERASE;
					end
				end else if (weRise &&
					(q.pendSectorErase || q.pendChipErase)) begin
					next_q.pendSectorErase = 1'b0;
					next_q.pendChipErase = 1'b0;
					next_q.eraseKind = 1'b1;
					next_q.suspendBase = 1'b0;
					if (allSelectedProtected) begin
						next_q.op = flash_status_pkg::OP_PROT_POLL;
						next_q.waitCount = 16'(
							flash_status_pkg::ALL_PROT_ERASE_POLL_CYCLES - 1);
					end else if (q.pendSectorErase) begin
						next_q.op = flash_status_pkg::OP_ERASE_WINDOW;
						next_q.windowClosed = 1'b0;
					end else begin
						// Chip erase has no acceptance window
						next_q.op = flash_status_pkg::OP_ERASE;
						next_q.windowClosed = 1'b1;
					end
				end
			end
			flash_status_pkg::OP_PROGRAM,
			flash_status_pkg::OP_SUSPEND_PROGRAM: begin
				if (pulseLimitHit) begin
					next_q.op = flash_status_pkg::OP_FAILED;
					next_q.timeoutFail = 1'b1;
				end else if (programDone) begin
					next_q.op = programBusy && q.suspendBase ?
						flash_status_pkg::OP_SUSPEND :
						flash_status_pkg::OP_IDLE;
					if (q.op == flash_status_pkg::OP_SUSPEND_PROGRAM) begin
						next_q.op = flash_status_pkg::OP_SUSPEND;
						next_q.eraseKind = 1'b1;
					end
				end
			end
			flash_status_pkg::OP_PROT_POLL: begin
				if (q.waitCount == 16'h0000 || cmdReset) begin
					next_q.op = q.suspendBase ?
						flash_status_pkg::OP_SUSPEND :
						flash_status_pkg::OP_IDLE;
					next_q.eraseKind = q.suspendBase;
				end else begin
					next_q.waitCount = q.waitCount - 16'h0001;
				end
			end
			flash_status_pkg::OP_ERASE_WINDOW: begin
				if (pulseLimitHit) begin
					next_q.op = flash_status_pkg::OP_FAILED;
					next_q.timeoutFail = 1'b1;
				end else if (eraseWindowEnd) begin
					next_q.op = flash_status_pkg::OP_ERASE;
					next_q.windowClosed = 1'b1;
				end
			end
			flash_status_pkg::OP_ERASE: begin
				// Once erasing, suspend is the only command heeded
				if (pulseLimitHit) begin
					next_q.op = flash_status_pkg::OP_FAILED;
					next_q.timeoutFail = 1'b1;
				end else if (eraseDone) begin
					next_q.op = flash_status_pkg::OP_IDLE;
					next_q.eraseKind = 1'b0;
				end else if (cmdSuspend) begin
					next_q.op = flash_status_pkg::OP_SUSPEND;
				end
				next_q.pendProgram = 1'b0;
				next_q.pendSectorErase = 1'b0;
				next_q.pendChipErase = 1'b0;
			end
			flash_status_pkg::OP_FAILED: begin
				if (cmdReset) begin
					next_q.op = q.suspendBase ?
						flash_status_pkg::OP_SUSPEND :
						flash_status_pkg::OP_IDLE;
					next_q.eraseKind = q.suspendBase;
					next_q.timeoutFail = 1'b0;
				end
			end
			default: begin
				next_q.op = flash_status_pkg::OP_IDLE;
			end
		endcase

		// Arming after the update: outside OP_ERASE a new command wins over a clear
		if (q.op != flash_status_pkg::OP_ERASE) begin
			if (cmdProgram) begin
				next_q.pendProgram = 1'b1;
			end
			if (cmdSectorErase) begin
				next_q.pendSectorErase = 1'b1;
			end
			if (cmdChipErase) begin
				next_q.pendChipErase = 1'b1;
			end
		end

		if (readDone && readBankBusy && bankToggles) begin
			next_q.bankToggle = !q.bankToggle;
		end
		if (readDone && readBankBusy && readSectorSelected &&
			sectorToggles) begin
			next_q.sectorToggle = !q.sectorToggle;
		end

		// Output word is rebuilt every cycle, so a finished operation
		// shows full array data on the following read
		next_q.busOeN = !readActive;
		if (statusMode) begin
			next_q.busData = 16'h0000;
			next_q.busData[flash_status_pkg::POLL_BIT] = pollValue;
			next_q.busData[flash_status_pkg::BANK_TOGGLE_BIT] = q.bankToggle;
			next_q.busData[flash_status_pkg::TIMEOUT_BIT] = q.timeoutFail;
			next_q.busData[flash_status_pkg::TIMER_BIT] = q.windowClosed;
			next_q.busData[flash_status_pkg::SECTOR_TOGGLE_BIT] =
				q.sectorToggle;
		end else begin
			next_q.busData = arrayData;
		end

		// Burst clock period, measured in system cycles
		if (clkRise) begin
			next_q.clkPeriod = 16'h0000;
			next_q.slowClock = q.clkPeriod >=
				flash_status_pkg::SLOW_PERIOD_LAST;
			next_q.thirdCount = q.thirdCount == flash_status_pkg::THIRD_WRAP
				? 2'h0 : q.thirdCount + 2'h1;
		end else if (q.clkPeriod != flash_status_pkg::PERIOD_SATURATE) begin
			next_q.clkPeriod = q.clkPeriod + 16'h0001;
		end

		if (ceFall) begin
			next_q.latency = initialWait;
			next_q.burstAddr = startAddrLow;
			next_q.boundaryHold = 1'b0;
		end else if (clkRise) begin
			if (q.latency != 4'h0) begin
				next_q.latency = q.latency - 4'h1;
				next_q.boundaryHold = 1'b0;
			end else begin
				next_q.boundaryHold =
					q.burstAddr == flash_status_pkg::BOUNDARY_ADDR;
				next_q.burstAddr = q.burstAddr + 6'h01;
			end
		end

		// Ready is driven low only while selected
		next_q.readyOeN = q.pinSync.chipSelN;
		if (!burstMode || q.pinSync.outEnN) begin
			next_q.ready = 1'b1;
		end else begin
			next_q.ready = next_q.latency == 4'h0 && !next_q.boundaryHold &&
				!(next_q.slowClock &&
				next_q.thirdCount == flash_status_pkg::THIRD_CLOCK);
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			q <= '0;
			q.pinMeta <= '1;
			q.pinSync <= '1;
			q.pinPrev <= '1;
			q.busOeN <= 1'b1;
			q.ready <= 1'b1;
			q.readyOeN <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign busData = q.busData;
	assign busOeN = q.busOeN;
	assign ready = q.ready;
	assign readyOeN = q.readyOeN;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence burstRead;
		burstMode && readActive;
	endsequence

	sequence hitBoundary;
		clkRise && !ceFall && q.latency == 4'h0 &&
			q.burstAddr == flash_status_pkg::BOUNDARY_ADDR;
	endsequence

	chk_prog_poll: assert property (
		q.op == flash_status_pkg::OP_PROGRAM && readBankBusy
		|=> busData[flash_status_pkg::POLL_BIT] == !$past(programDatumMsb))
		else $error("Program poll bit not inverted");

	chk_erase_poll: assert property (
		q.op == flash_status_pkg::OP_ERASE && readBankBusy
		|=> busData[flash_status_pkg::POLL_BIT] == 1'b0)
		else $error("Erase poll bit not zero");

	chk_bank_toggle_flip: assert property (
		readDone && readBankBusy && q.op == flash_status_pkg::OP_ERASE
		|=> q.bankToggle != $past(q.bankToggle))
		else $error("Bank toggle did not invert");

	chk_idle_toggle_hold: assert property (
		q.op == flash_status_pkg::OP_IDLE |=> $stable(q.bankToggle))
		else $error("Bank toggle moved while idle");

	chk_program_sector_hold: assert property (
		programBusy |=> $stable(q.sectorToggle))
		else $error("Sector toggle moved while programming");

	chk_ready_async: assert property (
		!burstMode && !q.pinSync.chipSelN |=> !readyOeN && ready)
		else $error("Ready not driven high in async mode");

	chk_ready_float: assert property (
		q.pinSync.chipSelN |=> readyOeN)
		else $error("Ready driven while deselected");

	chk_ready_boundary: assert property (
		hitBoundary and burstRead |=> !ready)
		else $error("Ready high across burst boundary");

	chk_fail_timeout: assert property (
		pulseLimitHit &&
		(programBusy || q.op == flash_status_pkg::OP_ERASE)
		|=> q.op == flash_status_pkg::OP_FAILED && q.timeoutFail
		##1 busData[flash_status_pkg::TIMEOUT_BIT] || !$past(statusMode))
		else $error("Timeout bit not set on pulse limit");

	chk_reset_return: assert property (
		q.op == flash_status_pkg::OP_FAILED && cmdReset
		|=> (q.op == flash_status_pkg::OP_IDLE ||
		q.op == flash_status_pkg::OP_SUSPEND) && !q.timeoutFail)
		else $error("Reset did not leave failed state");

	chk_window_timer: assert property (
		q.op == flash_status_pkg::OP_ERASE_WINDOW && eraseWindowEnd &&
		!pulseLimitHit |=> q.windowClosed ##1 q.op != 
		flash_status_pkg::OP_ERASE_WINDOW)
		else $error("Erase timer bit not set after window");

endmodule

// *** tb/flash_host_model.sv ***
// Host controller model: pin strobes, status reads and toggle polling
`timescale 1ns/1ps

module flash_host_model (
	input wire logic clock,
	input wire logic [15:0] busData,
	output logic chipSelN,
	output logic outEnN,
	output logic writeEnN,
	output logic burstClk
);
	localparam int SETTLE = 5;
	bit burstRun;

	initial begin
		chipSelN = 1'b1;
		outEnN = 1'b1;
		writeEnN = 1'b1;
		burstClk = 1'b0;
		burstRun = 1'b0;
		#7;
		// Burst clock stands still low outside frames
		forever begin
			#100;
			burstClk = burstRun ? ~burstClk : 1'b0;
		end
	end

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask

	task automatic setPins(input logic cs, input logic oe);
		idle(1);
		chipSelN = cs;
		outEnN = oe;
	endtask

	task automatic setBurst(input bit on);
		burstRun = on;
	endtask

	// Final write of a command sequence; its rising edge starts the op
	task automatic writeStrobe();
		setPins(1'b0, 1'b1);
		writeEnN = 1'b0;
		idle(SETTLE);
		writeEnN = 1'b1;
		idle(SETTLE);
		chipSelN = 1'b1;
		idle(SETTLE);
	endtask

	// Data taken while output enable is low, then both strobes released
	task automatic readWord(output logic [15:0] d);
		setPins(1'b0, 1'b0);
		idle(SETTLE);
		d = busData;
		chipSelN = 1'b1;
		outEnN = 1'b1;
		idle(SETTLE);
	endtask

	// Always starts from a fresh double read, never a stale value
	task automatic pollPair(output logic [15:0] a, output logic [15:0] b);
		readWord(a);
		readWord(b);
	endtask
endmodule

// *** tb/flash_status_reporter_bench.sv ***
// Self-checking bench of the write-status reporter
`timescale 1ns/1ps

module flash_status_reporter_bench;
	localparam int LIMIT = 40000;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic chipSelN, outEnN, writeEnN, burstClk;
	logic burstMode = 1'b0;
	logic [3:0] initialWait = 4'h3;
	logic [5:0] startAddrLow = 6'h3c;
	logic cmdProgram = 1'b0, cmdSectorErase = 1'b0, cmdChipErase = 1'b0;
	logic eraseWindowEnd = 1'b0, cmdSuspend = 1'b0, cmdResume = 1'b0;
	logic cmdReset = 1'b0, programDone = 1'b0, eraseDone = 1'b0;
	logic pulseLimitHit = 1'b0, targetProtected = 1'b0;
	logic allSelectedProtected = 1'b0, programDatumMsb = 1'b0;
	logic readBankBusy = 1'b0, readSectorSelected = 1'b0;
	logic [15:0] arrayData = 16'h0000;
	logic [15:0] busData;
	logic busOeN, ready, readyOeN;
	logic [15:0] a, b;
	logic msb;
	int seed = 20;
	int nErrors = 0;
	int nChecks = 0;
	int cycles = 0;
	int lows, highs;

	flash_status_reporter flash_status_reporter_inst (.clock(clock),
		.reset_n(reset_n), .chipSelN(chipSelN), .outEnN(outEnN),
		.writeEnN(writeEnN), .burstClk(burstClk), .burstMode(burstMode),
		.initialWait(initialWait), .startAddrLow(startAddrLow),
		.cmdProgram(cmdProgram), .cmdSectorErase(cmdSectorErase),
		.cmdChipErase(cmdChipErase), .eraseWindowEnd(eraseWindowEnd),
		.cmdSuspend(cmdSuspend), .cmdResume(cmdResume),
		.cmdReset(cmdReset), .programDone(programDone),
		.eraseDone(eraseDone), .pulseLimitHit(pulseLimitHit),
		.targetProtected(targetProtected),
		.allSelectedProtected(allSelectedProtected),
		.programDatumMsb(programDatumMsb), .readBankBusy(readBankBusy),
		.readSectorSelected(readSectorSelected), .arrayData(arrayData),
		.busData(busData), .busOeN(busOeN), .ready(ready),
		.readyOeN(readyOeN));

	flash_host_model flash_host_model_inst (.clock(clock),
		.busData(busData), .chipSelN(chipSelN), .outEnN(outEnN),
		.writeEnN(writeEnN), .burstClk(burstClk));

	initial begin
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			nErrors++;
			end_sim();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
		step(1);
	endtask

	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		nChecks++;
		if (g !== e) begin
			nErrors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	// Status word with both toggle bits masked out
	function automatic logic [15:0] expStatus(input logic poll,
		input logic tout, input logic timer);
		return {8'h00, poll, 1'b0, tout, 1'b0, timer, 3'h0};
	endfunction

	// Address flags stand for the address the host puts on the bus
	task automatic rd2(input logic busy, input logic sel);
		readBankBusy = busy;
		readSectorSelected = sel;
		flash_host_model_inst.pollPair(a, b);
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		step(6);
		reset_n = 1'b1;
		step(3);
		for (int i = 0; i < 3; i++) begin
			msb = 1'($random(seed));
			arrayData = 16'($random(seed));
			programDatumMsb = msb;
			pulse(cmdProgram);
			flash_host_model_inst.writeStrobe();
			rd2(1'b1, 1'b0);
			chk("program status", expStatus(~msb, 1'b0, 1'b0),
				a & 16'hffbb);
			chk("program toggles", 16'h2, {14'h0, a[6] ^ b[6], a[2] ^ b[2]});
			rd2(1'b0, 1'b0);
			chk("idle bank", arrayData, a);
			pulse(programDone);
			rd2(1'b1, 1'b0);
			chk("program done", arrayData, b);
		end
		pulse(cmdSectorErase);
		flash_host_model_inst.writeStrobe();
		rd2(1'b1, 1'b1);
		chk("erase window", expStatus(1'b0, 1'b0, 1'b0),
			a & 16'hffbb);
		chk("window toggle", 16'h1, {15'h0, a[6] ^ b[6]});
		pulse(eraseWindowEnd);
		rd2(1'b1, 1'b1);
		chk("erase running", expStatus(1'b0, 1'b0, 1'b1),
			a & 16'hffbb);
		chk("erase toggles", 16'h3, {14'h0, a[6] ^ b[6], a[2] ^ b[2]});
		rd2(1'b1, 1'b0);
		chk("unselected toggles", 16'h2, {14'h0, a[6] ^ b[6], a[2] ^ b[2]});
		pulse(cmdSuspend);
		rd2(1'b1, 1'b1);
		chk("suspend poll", 16'h1, {15'h0, b[7]});
		chk("suspend toggles", 16'h1, {14'h0, a[6] ^ b[6], a[2] ^ b[2]});
		rd2(1'b1, 1'b0);
		chk("suspend array", arrayData, a);
		pulse(cmdProgram);
		flash_host_model_inst.writeStrobe();
		rd2(1'b1, 1'b0);
		// Erase timer bit keeps its closed value while suspended
		chk("suspend program", expStatus(~msb, 1'b0, 1'b1),
			a & 16'hffbb);
		chk("suspend prog toggle", 16'h2, {14'h0, a[6] ^ b[6], a[2] ^ b[2]});
		pulse(programDone);
		rd2(1'b1, 1'b1);
		chk("resuspended", 16'h0, {15'h0, a[6] ^ b[6]});
		pulse(cmdResume);
		pulse(eraseDone);
		rd2(1'b1, 1'b1);
		chk("erase done", arrayData, b);
		pulse(cmdProgram);
		flash_host_model_inst.writeStrobe();
		pulse(pulseLimitHit);
		rd2(1'b1, 1'b0);
		chk("timeout bit", {13'h0, 1'b1, 1'b1, ~msb},
			{13'h0, a[6] ^ b[6], b[5], b[7]});
		// Reset command is a plain decoder pulse here, no write cycle
		pulse(cmdReset);
		rd2(1'b1, 1'b0);
		chk("reset array", arrayData, b);
		for (int k = 0; k < 2; k++) begin
			targetProtected = (k == 0);
			allSelectedProtected = (k == 1);
			if (k == 0) begin
				pulse(cmdProgram);
			end else begin
				pulse(cmdChipErase);
			end
			flash_host_model_inst.writeStrobe();
			rd2(1'b1, 1'b1);
			chk("protected poll", {15'h0, k == 0 ? ~msb : 1'b0}, {15'h0, a[7]});
			chk("protected toggle", 16'h1, {15'h0, a[6] ^ b[6]});
			step(k == 0 ? flash_status_pkg::PROT_PROGRAM_POLL_CYCLES :
				flash_status_pkg::ALL_PROT_ERASE_POLL_CYCLES);
			rd2(1'b1, 1'b1);
			chk("protected ends", arrayData, b);
		end
		burstMode = 1'b1;
		flash_host_model_inst.setPins(1'b0, 1'b1);
		step(5);
		chk("burst no output", 16'h2, {14'h0, ready, readyOeN});
		flash_host_model_inst.setPins(1'b1, 1'b1);
		step(5);
		chk("deselected float", 16'h1, {15'h0, readyOeN});
		flash_host_model_inst.setPins(1'b0, 1'b0);
		step(5);
		chk("initial access", 16'h0, {15'h0, ready});
		flash_host_model_inst.setBurst(1'b1);
		step(48);
		lows = 0;
		highs = 0;
		repeat (96) begin
			step(1);
			lows += int'(ready === 1'b0);
			highs += int'(ready === 1'b1);
		end
		// 200 ns burst clock counts as slow, so drops must appear
		chk("slow clock drops", 16'h3, {14'h0, lows != 0, highs != 0});
		flash_host_model_inst.setBurst(1'b0);
		flash_host_model_inst.setPins(1'b1, 1'b1);
		burstMode = 1'b0;
		flash_host_model_inst.setPins(1'b0, 1'b0);
		step(5);
		chk("async ready", 16'h2, {14'h0, ready, readyOeN});
		chk("bus driven", 16'h0, {15'h0, busOeN});
		flash_host_model_inst.setPins(1'b1, 1'b1);
		step(5);
		chk("bus released", 16'h1, {15'h0, busOeN});
		end_sim();
	end
endmodule
